// *** logic/jtlm_lane_out.sv ***
// Transmit lane output: lane map, test patterns, lane groups, power-down
`timescale 1ns/1ps
// Function
// [RL1] 9-bit dual mode: lane k sends samples k and k+4, 3 zero pads
// [RL2] Sync header check offers only the 12-bit CRC, never CRC-3
// [RL3] Sync header alternatively uses forward error correction
// [RL4] Redundant lane group only in link modes with four lanes or fewer
// [RL5] Group select 0 drives D3-D0, 1 drives D7-D4, one group only
// [RL6] Full power-down input high disables all serial output drivers
// [RL7] Configuration registers survive power-down untouched
// [RL8] Receiver re-links after power-down and drops stale pipeline data
// [RL9] Test selector picks test; lane count follows link mode always
// [RL10] Controller changes test selector only while link is disabled
// [RL11] PRBS modes bypass transport and link layers, no scramble or code
// [RL12] PRBS 7/9/15/23/31 generators from two-tap XOR recursions
// [RL13] Each lane PRBS starts at a different phase
// [RL14] Clock pattern bypasses layers, repeats 1111111100000000 per lane
// [RL15] Ramp: link layer normal, transport off, sample data ignored
// [RL16] Ramp starts after alignment or serializer initialization done
// [RL17] Ramp: identical 0x00..0xFF octets on all lanes, encoded, scrambled
// [RL18] Short transport test repeats a fixed octet pattern each frame
// [RL19] No long transport test pattern is offered
// [RL20] Short test words F01..F05 on D0 down to 871 on D7, tail bits
// [RL21] 9-bit quad mode: lane pairs carry two samples each, zero padded
// [RL22] Unknown test selector value keeps normal sample data path
module jtlm_lane_out (
	input wire logic clk,
	input wire logic reset,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic fullPowerdownInput,
	input wire logic initDone,
	input wire logic [7:0][8:0] sampA,
	input wire logic [7:0][8:0] sampB,
	input wire logic [7:0][8:0] sampC,
	input wire logic [7:0][8:0] sampD,
	output logic [7:0][23:0] laneWord,
	output logic [7:0] laneDrvEn,
	output logic laneBypass,
	output logic syncHdrFec
);
	// ==========================================================
	// Functions
	function automatic logic [54:0] prbsRun(input logic [30:0] s,
		input jtlm_pkg::jtlm_test_e sel);
		int a;
		int b;
		logic nb;
		logic [23:0] o;
		a = 5;
		b = 6;
		o = 24'h000000;
		case (sel)
			jtlm_pkg::TS_PRBS9: begin a = 4; b = 8; end
			jtlm_pkg::TS_PRBS15: begin a = 13; b = 14; end
			jtlm_pkg::TS_PRBS23: begin a = 17; b = 22; end
			jtlm_pkg::TS_PRBS31: begin a = 27; b = 30; end
			default: begin a = 5; b = 6; end
		endcase
		for (int i = 0; i < jtlm_pkg::WORD_W; i++) begin
			nb = s[a] ^ s[b];
			s = {s[29:0], nb};
			o = {o[22:0], nb};
		end
		return {o, s};
	endfunction

	function automatic logic [23:0] rot(input logic [63:0] pat,
		input logic [5:0] ph);
		logic [127:0] dbl;
		dbl = {pat, pat};
		return dbl[7'(7'd127 - {1'b0, ph}) -: 24];
	endfunction

	function automatic logic [63:0] shortFrame(input int k);
		logic [63:0] f;
		f = 64'h0;
		for (int j = 1; j <= 5; j++) begin
			f = {f[51:0], 4'(15 - k), 4'(k), 4'(j)};
		end
		return {f[59:0], jtlm_pkg::TAIL_BITS};
	endfunction

	function automatic logic [3:0] laneCount(input logic [4:0] m);
		case (m)
			jtlm_pkg::MODE_SHORT_REF,
			jtlm_pkg::MODE_9B_QUAD,
			jtlm_pkg::MODE_9B_DUAL: return 4'h8;
			default: return 4'h4;
		endcase
	endfunction

	function automatic logic [23:0] pair(input logic [8:0] x,
		input logic [8:0] y);
		return {x, jtlm_pkg::PAD_ZERO, y, jtlm_pkg::PAD_ZERO};
	endfunction

	// ==========================================================
	// Register bus
	logic [31:0] ctrl_r;
	logic wrPend_r;
	logic [7:0] wrAddr_r;
	logic [31:0] rdData_nxt;
	logic [31:0] status;
	logic addrPhase;
	logic [4:0] linkMode;
	logic linkEn;
	logic altSel;
	jtlm_pkg::jtlm_test_e testMode_r;
	logic [7:0] laneMask;

	assign addrPhase = hsel && htrans[1] && hready;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign linkMode = ctrl_r[jtlm_pkg::CTRL_MODE_LSB +: jtlm_pkg::CTRL_MODE_W];
	assign linkEn = ctrl_r[jtlm_pkg::CTRL_LINKEN_BIT];
	assign altSel = ctrl_r[jtlm_pkg::CTRL_ALT_BIT];
	assign syncHdrFec = ctrl_r[jtlm_pkg::CTRL_FEC_BIT]; // [RL2] [RL3]

	always_ff @(posedge clk) begin
		if (reset) begin
			wrPend_r <= 1'b0;
			wrAddr_r <= 8'h00;
		end else begin
			wrPend_r <= addrPhase && hwrite;
			wrAddr_r <= haddr[7:0];
		end
	end

	// Power-down never touches the configuration
	always_ff @(posedge clk) begin
		if (reset) begin
			ctrl_r <= jtlm_pkg::CTRL_RESET;
		end else if (wrPend_r && wrAddr_r == jtlm_pkg::CTRL_ADDR) begin
			ctrl_r <= hwdata; // [RL7]
		end
	end

	always_comb begin
		status = 32'h0000_0000;
		status[jtlm_pkg::STAT_DRV_LSB +: 8] = laneDrvEn;
		status[jtlm_pkg::STAT_PD_BIT] = fullPowerdownInput;
		status[jtlm_pkg::STAT_TEST_LSB +: 4] = testMode_r;
		status[jtlm_pkg::STAT_INIT_BIT] = initDone;
		status[jtlm_pkg::STAT_LINKEN_BIT] = linkEn;
		case (haddr[7:0])
			jtlm_pkg::CTRL_ADDR: rdData_nxt = ctrl_r;
			jtlm_pkg::STATUS_ADDR: rdData_nxt = status;
			default: rdData_nxt = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			hrdata <= 32'h0000_0000;
		end else if (addrPhase && !hwrite) begin
			hrdata <= rdData_nxt;
		end
	end

	// ==========================================================
	// Test selection, taken over only while the link is down
	// A live change would corrupt the receiver's lock mid-stream
	always_ff @(posedge clk) begin
		if (reset) begin
			testMode_r <= jtlm_pkg::TS_NORMAL;
		end else if (!linkEn) begin
			case (ctrl_r[jtlm_pkg::CTRL_TEST_LSB +: jtlm_pkg::CTRL_TEST_W])
				4'h1: testMode_r <= jtlm_pkg::TS_PRBS7;
				4'h2: testMode_r <= jtlm_pkg::TS_PRBS9;
				4'h3: testMode_r <= jtlm_pkg::TS_PRBS15;
				4'h4: testMode_r <= jtlm_pkg::TS_PRBS23;
				4'h5: testMode_r <= jtlm_pkg::TS_PRBS31;
				4'h6: testMode_r <= jtlm_pkg::TS_CLOCK;
				4'h7: testMode_r <= jtlm_pkg::TS_RAMP;
				4'h8: testMode_r <= jtlm_pkg::TS_SHORT;
				default: testMode_r <= jtlm_pkg::TS_NORMAL; // [RL22] [RL19]
			endcase // [RL9] [RL10]
		end
	end

	// ==========================================================
	// Pattern generators
	logic [7:0][30:0] prbs_r;
	logic [7:0][54:0] prbs_nxt;
	logic [5:0] phase_r;
	logic [7:0] ramp_r;
	logic isPrbs;

	assign isPrbs = testMode_r inside {jtlm_pkg::TS_PRBS7, jtlm_pkg::TS_PRBS9,
		jtlm_pkg::TS_PRBS15, jtlm_pkg::TS_PRBS23, jtlm_pkg::TS_PRBS31};

	// One generator run per lane feeds both the state and the word
	always_comb begin
		for (int k = 0; k < jtlm_pkg::LANES; k++) begin
			prbs_nxt[k] = prbsRun(prbs_r[k], testMode_r); // [RL12]
		end
	end

	always_ff @(posedge clk) begin
		if (reset || !linkEn) begin
			for (int k = 0; k < jtlm_pkg::LANES; k++) begin
				prbs_r[k] <= 31'(8'(k) * jtlm_pkg::SEED_MUL + 8'h01); // [RL13]
			end
		end else if (isPrbs) begin
			for (int k = 0; k < jtlm_pkg::LANES; k++) begin
				prbs_r[k] <= prbs_nxt[k][30:0]; // [RL12]
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset || !linkEn) begin
			phase_r <= 6'h00;
		end else begin
			phase_r <= phase_r + jtlm_pkg::PHASE_STEP; // [RL14] [RL18]
		end
	end

	// Ramp holds at zero until the link has finished its start-up
	always_ff @(posedge clk) begin
		if (reset || !linkEn || !initDone) begin
			ramp_r <= 8'h00; // [RL16]
		end else if (testMode_r == jtlm_pkg::TS_RAMP) begin
			ramp_r <= ramp_r + jtlm_pkg::RAMP_STEP; // [RL17]
		end
	end

	// ==========================================================
	// Lane data selection
	logic [7:0][23:0] normWord;
	logic [7:0][23:0] word_nxt;
	logic [23:0] rampWord;

	assign rampWord = {ramp_r, 8'(ramp_r + 8'h01), 8'(ramp_r + 8'h02)};

	always_comb begin
		for (int k = 0; k < jtlm_pkg::LANES; k++) begin
			normWord[k] = 24'h000000;
		end
		case (linkMode)
			jtlm_pkg::MODE_9B_DUAL: begin
				for (int k = 0; k < 4; k++) begin
					normWord[k] = pair(sampA[k], sampA[k + 4]); // [RL1]
					normWord[k + 4] = pair(sampB[k], sampB[k + 4]); // [RL1]
				end
			end
			jtlm_pkg::MODE_9B_QUAD: begin
				for (int j = 0; j < 2; j++) begin
					normWord[j] = pair(sampA[j], sampA[j + 2]); // [RL21]
					normWord[j + 2] = pair(sampB[j], sampB[j + 2]); // [RL21]
					normWord[j + 4] = pair(sampC[j], sampC[j + 2]); // [RL21]
					normWord[j + 6] = pair(sampD[j], sampD[j + 2]); // [RL21]
				end
			end
			default: begin
				for (int k = 0; k < jtlm_pkg::LANES; k++) begin
					normWord[k] = 24'h000000;
				end
			end
		endcase
		for (int k = 0; k < jtlm_pkg::LANES; k++) begin
			case (testMode_r)
				jtlm_pkg::TS_PRBS7, jtlm_pkg::TS_PRBS9, jtlm_pkg::TS_PRBS15,
				jtlm_pkg::TS_PRBS23, jtlm_pkg::TS_PRBS31:
					word_nxt[k] = prbs_nxt[k][54:31]; // [RL11]
				jtlm_pkg::TS_CLOCK:
					word_nxt[k] = rot({4{jtlm_pkg::CLOCK_PATTERN}}, phase_r); // [RL14]
				jtlm_pkg::TS_RAMP:
					word_nxt[k] = initDone ? rampWord : 24'h000000; // [RL15]
				jtlm_pkg::TS_SHORT:
					word_nxt[k] = rot(shortFrame(k), phase_r); // [RL20]
				default: word_nxt[k] = normWord[k]; // [RL22]
			endcase
		end
		// Narrow modes may be steered onto the upper group as a spare
		if (laneCount(linkMode) <= 4'h4 && altSel) begin
			for (int k = 0; k < 4; k++) begin
				word_nxt[k + 4] = word_nxt[k]; // [RL4] [RL5]
				word_nxt[k] = 24'h000000; // [RL5]
			end
		end else if (laneCount(linkMode) <= 4'h4) begin
			for (int k = 4; k < 8; k++) begin
				word_nxt[k] = 24'h000000; // [RL5]
			end
		end
	end

	always_comb begin
		if (laneCount(linkMode) == 4'h8) begin
			laneMask = 8'hFF; // [RL9] [RL4]
		end else begin
			laneMask = altSel ? 8'hF0 : 8'h0F; // [RL5]
		end
	end

	// ==========================================================
	// Output registers
	always_ff @(posedge clk) begin
		if (reset) begin
			laneWord <= '0;
			laneBypass <= 1'b0;
		end else begin
			laneWord <= word_nxt;
			laneBypass <= isPrbs || testMode_r == jtlm_pkg::TS_CLOCK; // [RL11] [RL14]
		end
	end

	always_ff @(posedge clk) begin
		if (reset || fullPowerdownInput || !linkEn) begin
			laneDrvEn <= 8'h00; // [RL6]
		end else begin
			laneDrvEn <= laneMask;
		end
	end

	// ==========================================================
	// Assertions
	sequence pdHigh;
		fullPowerdownInput;
	endsequence

	sequence rampRun;
		testMode_r == jtlm_pkg::TS_RAMP && linkEn && initDone;
	endsequence

	pd_drv_off_a: assert property (@(posedge clk) disable iff (reset) // [RL6]
		pdHigh |=> laneDrvEn == 8'h00)
		else $error("drivers on during power-down");

	pd_keep_cfg_a: assert property (@(posedge clk) disable iff (reset) // [RL7]
		pdHigh ##0 !wrPend_r |=> ctrl_r == $past(ctrl_r))
		else $error("configuration lost in power-down");

	one_group_a: assert property (@(posedge clk) disable iff (reset) // [RL5]
		laneDrvEn != 8'hFF |-> laneDrvEn[3:0] == 4'h0 || laneDrvEn[7:4] == 4'h0)
		else $error("both lane groups active");

	alt_group_a: assert property (@(posedge clk) disable iff (reset) // [RL4]
		linkEn && !fullPowerdownInput && altSel && laneCount(linkMode) == 4'h4
		|=> laneDrvEn == 8'hF0)
		else $error("alternate group not selected");

	test_hold_a: assert property (@(posedge clk) disable iff (reset) // [RL10]
		linkEn ##1 linkEn |-> $stable(testMode_r))
		else $error("test mode changed while link up");

	ramp_step_a: assert property (@(posedge clk) disable iff (reset) // [RL17]
		rampRun ##1 rampRun |-> ramp_r == 8'($past(ramp_r) + 8'h03))
		else $error("ramp step wrong");

	ramp_wait_a: assert property (@(posedge clk) disable iff (reset) // [RL16]
		!initDone |=> ramp_r == 8'h00)
		else $error("ramp ran before start-up");

	bypass_a: assert property (@(posedge clk) disable iff (reset) // [RL11]
		isPrbs |=> laneBypass && laneWord[0] == $past(word_nxt[0]))
		else $error("prbs not bypassing");

	clock_pat_a: assert property (@(posedge clk) disable iff (reset) // [RL14]
		testMode_r == jtlm_pkg::TS_CLOCK && linkEn && phase_r == 6'h00
		|=> (laneWord[3] | laneWord[7]) == 24'hFF00FF)
		else $error("clock pattern wrong");

	short_a: assert property (@(posedge clk) disable iff (reset) // [RL20]
		testMode_r == jtlm_pkg::TS_SHORT && linkEn && phase_r == 6'h00
		&& laneCount(linkMode) == 4'h8 |=> laneWord[7] == 24'h871872)
		else $error("short pattern wrong");

	norm_map_a: assert property (@(posedge clk) disable iff (reset) // [RL1]
		testMode_r == jtlm_pkg::TS_NORMAL && linkMode == jtlm_pkg::MODE_9B_DUAL
		|=> laneWord[5] == {$past(sampB[1]), 3'h0, $past(sampB[5]), 3'h0})
		else $error("dual lane map wrong");

	seed_a: assert property (@(posedge clk) disable iff (reset) // [RL13]
		!linkEn |=> prbs_r[0][6:0] != prbs_r[1][6:0])
		else $error("lane seeds equal");
endmodule

// *** include/jtlm_pkg.sv ***
// Constants and types for the transmit lane test and lane mode block
package jtlm_pkg;
	// ==========================================================
	// Register map (byte addresses)
	localparam logic [7:0] CTRL_ADDR = 8'h00;
	localparam logic [7:0] STATUS_ADDR = 8'h04;
	// ==========================================================
	// Control register fields
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_MODE_W = 5;
	localparam int CTRL_TEST_LSB = 8;
	localparam int CTRL_TEST_W = 4;
	localparam int CTRL_ALT_BIT = 12;
	localparam int CTRL_FEC_BIT = 13;
	localparam int CTRL_LINKEN_BIT = 16;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	// ==========================================================
	// Status register fields
	localparam int STAT_DRV_LSB = 0;
	localparam int STAT_PD_BIT = 8;
	localparam int STAT_TEST_LSB = 9;
	localparam int STAT_INIT_BIT = 13;
	localparam int STAT_LINKEN_BIT = 14;
	// ==========================================================
	// Lane and sample geometry
	localparam int LANES = 8;
	localparam int SAMP_W = 9;
	localparam int WORD_W = 24;
	localparam int FRAME_W = 64;
	localparam logic [5:0] PHASE_STEP = 6'h18;
	localparam logic [7:0] RAMP_STEP = 8'h03;
	localparam logic [2:0] PAD_ZERO = 3'h0;
	localparam logic [3:0] TAIL_BITS = 4'h0;
	localparam logic [15:0] CLOCK_PATTERN = 16'hFF00;
	localparam logic [7:0] SEED_MUL = 8'h25;
	// ==========================================================
	// Link modes handled here
	localparam logic [4:0] MODE_SHORT_REF = 5'h00;
	localparam logic [4:0] MODE_9B_QUAD = 5'h0E;
	localparam logic [4:0] MODE_9B_DUAL = 5'h0F;
	// ==========================================================
	// Serializer test selector
	typedef enum logic [3:0] {
		TS_NORMAL = 4'h0,
		TS_PRBS7 = 4'h1,
		TS_PRBS9 = 4'h2,
		TS_PRBS15 = 4'h3,
		TS_PRBS23 = 4'h4,
		TS_PRBS31 = 4'h5,
		TS_CLOCK = 4'h6,
		TS_RAMP = 4'h7,
		TS_SHORT = 4'h8
	} jtlm_test_e;
endpackage

// *** dv/jtlm_rx_model.sv ***
// Link receiver stand-in: alignment and flush after outages
`timescale 1ns/1ps
module jtlm_rx_model (
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] laneDrvEn,
	input wire logic slow,
	output logic initDone,
	output logic dataGood
);
	// ====
	// Alignment
	logic [5:0] cnt_r;
	always_ff @(posedge clk) begin
		if (reset || laneDrvEn == 8'h00) begin
			cnt_r <= 6'h00;
			initDone <= 1'b0;
			dataGood <= 1'b0;
		end else begin
			if (cnt_r != 6'h3F) begin
				cnt_r <= cnt_r + 6'h01;
			end
			initDone <= cnt_r >= (slow ? 6'h14 : 6'h02);
			// Stale pipeline words are dropped until flushed
			dataGood <= cnt_r >= 6'h30;
		end
	end
endmodule

// *** dv/jtlm_lane_out_tb.sv ***
// Self-checking bench for the transmit lane output block
`timescale 1ns/1ps
module jtlm_lane_out_tb;
	// ====
	// Signals
	logic clk = 0;
	logic reset = 1;
	logic hsel = 0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata, rd;
	logic hready, hresp, initDone, laneBypass, fec;
	logic pd = 0;
	logic slow = 0;
	logic [7:0][8:0] sA, sB, sC, sD;
	logic [7:0][23:0] laneWord;
	logic [7:0] laneDrvEn;
	logic dataGood;
	int n_mismatch = 0;
	int check_count = 0;
	int tapA[5] = '{6, 5, 14, 18, 28};
	int tapB[5] = '{7, 9, 15, 23, 31};
	always #2.5 clk = ~clk;
	jtlm_lane_out u_jtlm_lane_out (.clk(clk), .reset(reset),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
		.fullPowerdownInput(pd), .initDone(initDone), .sampA(sA),
		.sampB(sB), .sampC(sC), .sampD(sD), .laneWord(laneWord),
		.laneDrvEn(laneDrvEn), .laneBypass(laneBypass),
		.syncHdrFec(fec));
	jtlm_rx_model u_jtlm_rx_model (.clk(clk), .reset(reset),
		.laneDrvEn(laneDrvEn), .slow(slow), .initDone(initDone),
		.dataGood(dataGood));
	// ====
	// Helpers
	task automatic check(input string nm, input logic [63:0] s, e);
		check_count++;
		if (s !== e) begin
			n_mismatch++;
			$display("[ERR] %s exp %h seen %h", nm, e, s);
		end
	endtask
	task automatic end_of_test();
		if (n_mismatch == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic waitRdy();
		int t;
		t = 0;
		@(posedge clk);
		while (hready !== 1'b1 && t < 100) begin
			t++;
			@(posedge clk);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		waitRdy();
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		waitRdy();
		rd = hrdata;
	endtask
	function automatic logic [31:0] ctl(input logic [4:0] m,
		input logic [3:0] t, input logic a, f, e);
		ctl = 32'h00000000;
		ctl[jtlm_pkg::CTRL_MODE_LSB +: 5] = m;
		ctl[jtlm_pkg::CTRL_TEST_LSB +: 4] = t;
		ctl[jtlm_pkg::CTRL_ALT_BIT] = a;
		ctl[jtlm_pkg::CTRL_FEC_BIT] = f;
		ctl[jtlm_pkg::CTRL_LINKEN_BIT] = e;
	endfunction
	// Test select is only moved with the link down, then link is raised
	task automatic start(input logic [4:0] m, input logic [3:0] t,
		input logic a, f);
		int n;
		xfer(1'b1, jtlm_pkg::CTRL_ADDR, ctl(m, t, a, f, 1'b0));
		xfer(1'b1, jtlm_pkg::CTRL_ADDR, ctl(m, t, a, f, 1'b1));
		n = 0;
		while (laneDrvEn === 8'h00 && n < 20) begin
			n++;
			@(posedge clk);
		end
	endtask
	function automatic logic [8:0] smp(input int c, i);
		case (c)
			0: smp = sA[i];
			1: smp = sB[i];
			2: smp = sC[i];
			default: smp = sD[i];
		endcase
	endfunction
	task automatic chkLanes(input logic q);
		logic [8:0] x, y;
		for (int k = 0; k < 8; k++) begin
			x = q ? smp(k / 2, k % 2) : smp(k / 4, k % 4);
			y = q ? smp(k / 2, k % 2 + 2) : smp(k / 4, k % 4 + 4);
			check("map", laneWord[k], {x, 3'h0, y, 3'h0});
		end
	endtask
	task automatic prbs(input int c);
		logic ok;
		logic [95:0] s;
		logic [7:0][23:0] w[4];
		for (int i = 0; i < 4; i++) begin
			w[i] = laneWord;
			@(posedge clk);
		end
		check("bypass", laneBypass, 1'b1);
		for (int k = 0; k < 8; k++) begin
			s = {w[0][k], w[1][k], w[2][k], w[3][k]};
			ok = 1'b1;
			for (int n = tapB[c-1]; n < 96; n++)
				if (s[95-n] !== (s[95-n+tapA[c-1]] ^ s[95-n+tapB[c-1]]))
					ok = 1'b0;
			check("prbs", ok, 1'b1);
			check("phase", w[0][k] !== w[0][(k+1)%8], 1'b1);
		end
	endtask
	function automatic logic [23:0] shortW(input int k, i);
		logic [63:0] f;
		f = 64'h0;
		for (int j = 1; j <= 5; j++)
			f[64-12*j +: 12] = {4'(15-k), 4'(k), 4'(j)};
		for (int b = 0; b < 24; b++)
			shortW[23-b] = f[63-(24*i+b)%64];
	endfunction
	// ====
	// Tests
	initial begin
		int n;
		logic [7:0] r;
		for (int i = 0; i < 8; i++) begin
			sA[i] = 9'h1A0 + 9'(i);
			sB[i] = 9'h0B0 + 9'(i);
			sC[i] = 9'h1C0 + 9'(i);
			sD[i] = 9'h0D0 + 9'(i);
		end
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		xfer(1'b1, 8'h08, 32'hFFFFFFFF);
		xfer(1'b1, jtlm_pkg::STATUS_ADDR, 32'hFFFFFFFF);
		xfer(1'b0, jtlm_pkg::CTRL_ADDR, 32'h0);
		check("ctrl", rd, jtlm_pkg::CTRL_RESET);
		check("hresp", hresp, 1'b0);
		xfer(1'b0, 8'h08, 32'h0);
		check("unmapped", rd, 32'h0);
		xfer(1'b0, jtlm_pkg::STATUS_ADDR, 32'h0);
		check("status", rd, 32'h0);
		start(jtlm_pkg::MODE_9B_DUAL, jtlm_pkg::TS_NORMAL, 1'b1, 1'b1);
		check("drvEn", laneDrvEn, 8'hFF);
		check("fec", fec, 1'b1);
		chkLanes(1'b0);
		start(jtlm_pkg::MODE_9B_QUAD, 4'h9, 1'b0, 1'b0);
		check("fec", fec, 1'b0);
		chkLanes(1'b1);
		start(5'h01, jtlm_pkg::TS_CLOCK, 1'b0, 1'b0);
		check("drvEn", laneDrvEn, 8'h0F);
		check("clk", laneWord[0], 24'hFF00FF);
		check("bypass", laneBypass, 1'b1);
		@(posedge clk);
		check("clk", laneWord[3], 24'h00FF00);
		start(5'h01, jtlm_pkg::TS_CLOCK, 1'b1, 1'b0);
		check("drvEn", laneDrvEn, 8'hF0);
		xfer(1'b1, jtlm_pkg::CTRL_ADDR, ctl(5'h01, 4'h1, 1'b1, 1'b0, 1'b1));
		xfer(1'b0, jtlm_pkg::STATUS_ADDR, 32'h0);
		check("test", rd[jtlm_pkg::STAT_TEST_LSB +: 4], 4'h6);
		pd <= 1'b1;
		repeat (3) @(posedge clk);
		check("drvEn", laneDrvEn, 8'h00);
		xfer(1'b0, jtlm_pkg::STATUS_ADDR, 32'h0);
		check("pd", rd[jtlm_pkg::STAT_PD_BIT], 1'b1);
		xfer(1'b0, jtlm_pkg::CTRL_ADDR, 32'h0);
		check("ctrl", rd, ctl(5'h01, 4'h1, 1'b1, 1'b0, 1'b1));
		pd <= 1'b0;
		repeat (3) @(posedge clk);
		check("drvEn", laneDrvEn, 8'hF0);
		check("flush", dataGood, 1'b0);
		for (int c = 1; c <= 5; c++) begin
			start(jtlm_pkg::MODE_9B_DUAL, 4'(c), 1'b0, 1'b0);
			prbs(c);
		end
		start(jtlm_pkg::MODE_SHORT_REF, jtlm_pkg::TS_SHORT, 1'b0, 1'b0);
		for (int i = 0; i < 8; i++) begin
			for (int k = 0; k < 8; k++)
				check("short", laneWord[k], shortW(k, i));
			@(posedge clk);
		end
		// A slow receiver shows the ramp waiting for alignment
		slow <= 1'b1;
		start(jtlm_pkg::MODE_9B_DUAL, jtlm_pkg::TS_RAMP, 1'b0, 1'b0);
		check("held", laneWord[0], 24'h0);
		n = 0;
		while (laneWord[0] === 24'h0 && n < 60) begin
			n++;
			@(posedge clk);
		end
		r = 8'h00;
		for (int i = 0; i < 100; i++) begin
			for (int k = 0; k < 8; k++)
				check("ramp", laneWord[k], {r, r + 8'h01, r + 8'h02});
			r = r + 8'h03;
			if (i == 50)
				sA <= '0;
			@(posedge clk);
		end
		check("bypass", laneBypass, 1'b0);
		end_of_test();
	end
	// ====
	// Watchdog: the whole run needs well under 20000 cycles
	initial begin
		#100000;
		n_mismatch++;
		end_of_test();
	end
endmodule
